// File: sbcr_pkg.sv
// package: register map, field positions, codes and carriers of the sense control bank
package sbcr_pkg;

   // ======================================================
   // register addresses on the internal serial register port
   localparam logic [7:0] SBCR_ADDR_THR_A   = 8'h0F;
   localparam logic [7:0] SBCR_ADDR_THR_CAL = 8'h10;
   localparam logic [7:0] SBCR_ADDR_DT_MON  = 8'h11;
   localparam logic [7:0] SBCR_ADDR_LOCKED  = 8'h12;

   // ======================================================
   // reset values
   localparam logic [7:0] SBCR_RST_THR_A    = 8'h88;
   localparam logic [7:0] SBCR_RST_THR_CAL  = 8'h80;
   localparam logic [7:0] SBCR_RST_DT_MON   = 8'h00;

   // ======================================================
   // field positions
   localparam int SBCR_CMP1_LSB    = 4;
   localparam int SBCR_CMP2_LSB    = 0;
   localparam int SBCR_CMP3_LSB    = 4;
   localparam int SBCR_CAL_SEL_BIT = 3;
   localparam int SBCR_CAL1_BIT    = 2;
   localparam int SBCR_CAL2_BIT    = 1;
   localparam int SBCR_CAL3_BIT    = 0;
   localparam int SBCR_DT_DIS_BIT  = 7;
   localparam int SBCR_UNLOCK_BIT  = 5;
   localparam int SBCR_MON_LSB     = 0;
   // writable bit masks; reserved positions read as zero
   localparam logic [7:0] SBCR_MASK_DT_MON  = 8'hA7;

   // ======================================================
   // threshold code meaning disabled
   localparam logic [3:0] SBCR_THR_OFF = 4'h0;

   // ======================================================
   // monitor route codes
   typedef enum logic [2:0] {
      SBCR_MON_GND    = 3'h0,
      SBCR_MON_SUPPLY = 3'h1,
      SBCR_MON_TEMP   = 3'h2,
      SBCR_MON_REF    = 3'h3,
      SBCR_MON_A3_RES = 3'h4,
      SBCR_MON_AMP1   = 3'h5,
      SBCR_MON_AMP2   = 3'h6,
      SBCR_MON_A3_DIR = 3'h7
   } sbcr_mon_type;

   // source routed to the shared monitor pin; code 4 also sets series_res
   typedef struct packed {
      logic gnd_pulldown;
      logic supply;
      logic temp;
      logic amp_ref;
      logic amp_one;
      logic amp_two;
      logic amp_three;
      logic backemf;
      logic series_res;
   } sbcr_route_type;

   // calibration requests towards the analog side
   typedef struct packed {
      logic amp_one;
      logic amp_two;
      logic amp_three;
      logic backemf;
      logic input_shunt;
   } sbcr_cal_type;

endpackage

// File: sbcr_regs.sv
// module: sense block control registers, threshold/calibration/monitor controls
`timescale 1ns/100ps
module sbcr_regs (
   // clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   // register port from the serial interface
   input  wire logic                    reg_wr,
   input  wire logic [7:0]              reg_addr,
   input  wire logic [7:0]              reg_wdata,
   output logic      [7:0]              reg_rdata,
   // back-EMF enable from another control register
   input  wire logic                    backemf_sensing_enable,
   // calibration done pulses from the analog side
   input  wire logic                    cal_done_one,
   input  wire logic                    cal_done_two,
   input  wire logic                    cal_done_three,
   // controls to the analog side
   output logic      [3:0]              comparator_one_threshold,
   output logic      [3:0]              comparator_two_threshold,
   output logic      [3:0]              comparator_three_threshold,
   output logic                         comparator_one_enable,
   output logic                         comparator_two_enable,
   output logic                         comparator_three_enable,
   output sbcr_pkg::sbcr_cal_type       cal_request,
   output logic                         adaptive_deadtime_enable,
   output sbcr_pkg::sbcr_route_type     monitor_route,
   // locked register write strobe and offset-source clear
   output logic                         locked_write_strobe,
   output logic                         backemf_offset_clear
);

   // ======================================================
   // register state
   logic [7:0] thr_a_ff, nxt_thr_a;
   logic [7:0] thr_cal_ff, nxt_thr_cal;
   logic [7:0] dt_mon_ff, nxt_dt_mon;
   logic       bemf_cal_ff, nxt_bemf_cal;   // shared trigger target latched at start
   logic       wr_a, wr_c, wr_m;

   assign wr_a = reg_wr && (reg_addr == sbcr_pkg::SBCR_ADDR_THR_A);
   assign wr_c = reg_wr && (reg_addr == sbcr_pkg::SBCR_ADDR_THR_CAL);
   assign wr_m = reg_wr && (reg_addr == sbcr_pkg::SBCR_ADDR_DT_MON);

   // next values; a done pulse clears, a fresh 1 write in the same cycle wins
   always_comb begin
      nxt_thr_a    = wr_a ? reg_wdata : thr_a_ff;
      nxt_thr_cal  = thr_cal_ff;
      nxt_bemf_cal = bemf_cal_ff;
      if (cal_done_one) begin
         nxt_thr_cal[sbcr_pkg::SBCR_CAL1_BIT] = 1'b0;
      end
      if (cal_done_two) begin
         nxt_thr_cal[sbcr_pkg::SBCR_CAL2_BIT] = 1'b0;
      end
      if (cal_done_three) begin
         nxt_thr_cal[sbcr_pkg::SBCR_CAL3_BIT] = 1'b0;
      end
      if (wr_c) begin
         // writing 0 to a running trigger cannot abort it; only done clears
         nxt_thr_cal[7:3] = reg_wdata[7:3];
         for (int i = 0; i < 3; i++) begin
            if (reg_wdata[i]) begin
               nxt_thr_cal[i] = 1'b1;
            end
         end
         if (reg_wdata[sbcr_pkg::SBCR_CAL3_BIT] && !thr_cal_ff[sbcr_pkg::SBCR_CAL3_BIT]) begin
            nxt_bemf_cal = backemf_sensing_enable;
         end
      end
      // reserved bits held at zero whatever software writes
      nxt_dt_mon = wr_m ? (reg_wdata & sbcr_pkg::SBCR_MASK_DT_MON) : dt_mon_ff;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         thr_a_ff    <= sbcr_pkg::SBCR_RST_THR_A;
         thr_cal_ff  <= sbcr_pkg::SBCR_RST_THR_CAL;
         dt_mon_ff   <= sbcr_pkg::SBCR_RST_DT_MON;
         bemf_cal_ff <= 1'b0;
      end else begin
         thr_a_ff    <= nxt_thr_a;
         thr_cal_ff  <= nxt_thr_cal;
         dt_mon_ff   <= nxt_dt_mon;
         bemf_cal_ff <= nxt_bemf_cal;
      end
   end

   // ======================================================
   // decoded outputs, all registered
   logic [3:0]               nxt_c1, nxt_c2, nxt_c3;
   sbcr_pkg::sbcr_cal_type   nxt_cal;
   sbcr_pkg::sbcr_route_type nxt_route;
   logic [7:0]               nxt_rdata;
   logic                     nxt_lock_wr, nxt_off_clr;
   sbcr_pkg::sbcr_mon_type   mon_sel;

   assign mon_sel = sbcr_pkg::sbcr_mon_type'(dt_mon_ff[sbcr_pkg::SBCR_MON_LSB +: 3]);

   always_comb begin
      nxt_c1 = thr_a_ff[sbcr_pkg::SBCR_CMP1_LSB +: 4];
      nxt_c2 = thr_a_ff[sbcr_pkg::SBCR_CMP2_LSB +: 4];
      nxt_c3 = thr_cal_ff[sbcr_pkg::SBCR_CMP3_LSB +: 4];
      nxt_cal.amp_one     = thr_cal_ff[sbcr_pkg::SBCR_CAL1_BIT];
      nxt_cal.amp_two     = thr_cal_ff[sbcr_pkg::SBCR_CAL2_BIT];
      nxt_cal.amp_three   = thr_cal_ff[sbcr_pkg::SBCR_CAL3_BIT] && !bemf_cal_ff;
      nxt_cal.backemf     = thr_cal_ff[sbcr_pkg::SBCR_CAL3_BIT] && bemf_cal_ff;
      nxt_cal.input_shunt = thr_cal_ff[sbcr_pkg::SBCR_CAL_SEL_BIT];
      // monitor routing; codes 4 and 7 depend on back-EMF enable
      nxt_route = '0;
      unique case (mon_sel)
         sbcr_pkg::SBCR_MON_GND:    nxt_route.gnd_pulldown = 1'b1;
         sbcr_pkg::SBCR_MON_SUPPLY: nxt_route.supply = 1'b1;
         sbcr_pkg::SBCR_MON_TEMP:   nxt_route.temp = 1'b1;
         sbcr_pkg::SBCR_MON_REF:    nxt_route.amp_ref = 1'b1;
         sbcr_pkg::SBCR_MON_AMP1:   nxt_route.amp_one = 1'b1;
         sbcr_pkg::SBCR_MON_AMP2:   nxt_route.amp_two = 1'b1;
         sbcr_pkg::SBCR_MON_A3_RES, sbcr_pkg::SBCR_MON_A3_DIR: begin
            nxt_route.backemf    = backemf_sensing_enable;
            nxt_route.amp_three  = !backemf_sensing_enable;
            nxt_route.series_res = (mon_sel == sbcr_pkg::SBCR_MON_A3_RES);
         end
      endcase
      unique case (reg_addr)
         sbcr_pkg::SBCR_ADDR_THR_A:   nxt_rdata = thr_a_ff;
         sbcr_pkg::SBCR_ADDR_THR_CAL: nxt_rdata = thr_cal_ff;
         sbcr_pkg::SBCR_ADDR_DT_MON:  nxt_rdata = dt_mon_ff;
         default:                     nxt_rdata = 8'h00;
      endcase
      // locked register accepts writes only while unlocked
      nxt_lock_wr = reg_wr && (reg_addr == sbcr_pkg::SBCR_ADDR_LOCKED)
                    && dt_mon_ff[sbcr_pkg::SBCR_UNLOCK_BIT];
      nxt_off_clr = cal_done_three && thr_cal_ff[sbcr_pkg::SBCR_CAL3_BIT]
                    && bemf_cal_ff;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         comparator_one_threshold   <= sbcr_pkg::SBCR_RST_THR_A[7:4];
         comparator_two_threshold   <= sbcr_pkg::SBCR_RST_THR_A[3:0];
         comparator_three_threshold <= sbcr_pkg::SBCR_RST_THR_CAL[7:4];
         comparator_one_enable      <= 1'b1;
         comparator_two_enable      <= 1'b1;
         comparator_three_enable    <= 1'b1;
         cal_request                <= '0;
         adaptive_deadtime_enable   <= 1'b1;
         monitor_route              <= '0;
         reg_rdata                  <= 8'h00;
         locked_write_strobe        <= 1'b0;
         backemf_offset_clear       <= 1'b0;
      end else begin
         comparator_one_threshold   <= nxt_c1;
         comparator_two_threshold   <= nxt_c2;
         comparator_three_threshold <= nxt_c3;
         comparator_one_enable      <= (nxt_c1 != sbcr_pkg::SBCR_THR_OFF);
         comparator_two_enable      <= (nxt_c2 != sbcr_pkg::SBCR_THR_OFF);
         comparator_three_enable    <= (nxt_c3 != sbcr_pkg::SBCR_THR_OFF);
         cal_request                <= nxt_cal;
         adaptive_deadtime_enable   <= !dt_mon_ff[sbcr_pkg::SBCR_DT_DIS_BIT];
         monitor_route              <= nxt_route;
         reg_rdata                  <= nxt_rdata;
         locked_write_strobe        <= nxt_lock_wr;
         backemf_offset_clear       <= nxt_off_clr;
      end
   end

   // ======================================================
   // checks
   dt_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      adaptive_deadtime_enable == !$past(dt_mon_ff[7]))
      else $error("dead time enable wrong");
   // enables judged against the stored code, not against the output copy of it
   cmp1_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      comparator_one_enable == ($past(thr_a_ff[7:4]) != 4'h0))
      else $error("comparator one enable wrong");
   cmp2_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      comparator_two_enable == ($past(thr_a_ff[3:0]) != 4'h0))
      else $error("comparator two enable wrong");
   cmp3_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      comparator_three_enable == ($past(thr_cal_ff[7:4]) != 4'h0))
      else $error("comparator three enable wrong");
   cal1_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      thr_cal_ff[2] && !cal_done_one |=> thr_cal_ff[2])
      else $error("trigger one dropped early");
   cal1_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cal_done_one && !(wr_c && reg_wdata[2]) |=> !thr_cal_ff[2])
      else $error("trigger one not cleared");
   cal2_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cal_done_two && !(wr_c && reg_wdata[1]) |=> !thr_cal_ff[1])
      else $error("trigger two not cleared");
   cal3_route_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cal_request.amp_three |-> !cal_request.backemf && $past(thr_cal_ff[0])
                                && !$past(bemf_cal_ff))
      else $error("both third calibrations requested");
   lock_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      locked_write_strobe |-> $past(dt_mon_ff[5]) && $past(reg_wr)
                              && ($past(reg_addr) == sbcr_pkg::SBCR_ADDR_LOCKED))
      else $error("locked write passed while locked");
   mon_bemf_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      monitor_route.backemf |-> $past(backemf_sensing_enable))
      else $error("back-EMF routed while off");
   mon_gnd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      // the route still shows its reset value at the first edge after release
      $past(rst_n) && $past(dt_mon_ff[2:0]) == 3'h0 |-> monitor_route.gnd_pulldown)
      else $error("ground route missing");
   off_clr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      backemf_offset_clear |-> $past(cal_done_three) && $past(bemf_cal_ff))
      else $error("offset clear without back-EMF calibration");
   cal_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cal_request.input_shunt == $past(thr_cal_ff[3]))
      else $error("calibration input select wrong");

endmodule // sbcr_regs

// File: tb.sv
// testbench: self-checking scenarios for the sense block control register bank
`timescale 1ns/100ps
module tb;
   // =========================================================
   // clock, reset and design connections
   logic                     clk_sys, rst_n, reg_wr, backemf_sensing_enable;
   logic                     cal_done_one, cal_done_two, cal_done_three;
   logic [7:0]               reg_addr, reg_wdata, reg_rdata;
   logic [3:0]               thr1, thr2, thr3;
   logic                     en1, en2, en3, dt_en, lock_stb, off_clr;
   sbcr_pkg::sbcr_cal_type   cal_request;
   sbcr_pkg::sbcr_route_type monitor_route;
   int                       num_errors, checks_done, cycles, n_lock, n_off;

   sbcr_regs DUT (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .backemf_sensing_enable(backemf_sensing_enable), .cal_done_one(cal_done_one),
      .cal_done_two(cal_done_two), .cal_done_three(cal_done_three),
      .comparator_one_threshold(thr1), .comparator_two_threshold(thr2),
      .comparator_three_threshold(thr3), .comparator_one_enable(en1),
      .comparator_two_enable(en2), .comparator_three_enable(en3), .cal_request(cal_request),
      .adaptive_deadtime_enable(dt_en), .monitor_route(monitor_route),
      .locked_write_strobe(lock_stb), .backemf_offset_clear(off_clr));

   // =========================================================
   // 100 ns clock; hang guard well above the roughly 170 cycles needed
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (lock_stb === 1'b1) n_lock++;
      if (off_clr === 1'b1) n_off++;
      if (cycles == 3000) begin
         num_errors++;
         end_of_test();
      end
   end

   // =========================================================
   // shared helpers
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // outputs follow the register one edge after the write lands
   task automatic settle();
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(posedge clk_sys);
      reg_addr <= a;
      settle();
      check(name, {8'h00, reg_rdata}, {8'h00, exp});
   endtask
   task automatic done(input int which);
      @(posedge clk_sys);
      cal_done_one <= (which == 1);
      cal_done_two <= (which == 2);
      cal_done_three <= (which == 3);
      @(posedge clk_sys);
      {cal_done_one, cal_done_two, cal_done_three} <= 3'h0;
      settle();
   endtask
   // route bits: gnd,supply,temp,ref,amp1,amp2,amp3,backemf,series
   function automatic logic [8:0] route_exp(input logic [2:0] c, input logic bemf);
      case (c)
         3'h0: return 9'h100;
         3'h1: return 9'h080;
         3'h2: return 9'h040;
         3'h3: return 9'h020;
         3'h5: return 9'h010;
         3'h6: return 9'h008;
         3'h4: return bemf ? 9'h003 : 9'h005;
         default: return bemf ? 9'h002 : 9'h004;
      endcase
   endfunction

   // =========================================================
   // scenarios
   task automatic reset_and_thresholds();
      rd(8'h0F, 8'h88, "thr_a reset");
      rd(8'h10, 8'h80, "thr_cal reset");
      rd(8'h11, 8'h00, "dt_mon reset");
      rd(8'h13, 8'h00, "unmapped read");
      wr(8'h0F, 8'h0F);
      settle();
      check("cmp1", {11'h0, en1, thr1}, 16'h0000);
      check("cmp2", {11'h0, en2, thr2}, 16'h001F);
      wr(8'h0F, 8'h10);
      settle();
      check("cmp1 lo", {10'h0, en1, thr1, en2}, 16'h0022);
   endtask
   task automatic amp_calibrations();
      wr(8'h10, 8'h8C);
      settle();
      check("cal amp1", 16'(cal_request), 16'h0011);
      wr(8'h10, 8'h88);
      rd(8'h10, 8'h8C, "trigger held");
      done(1);
      check("cal amp1 end", 16'(cal_request), 16'h0001);
      rd(8'h10, 8'h88, "trigger cleared");
      wr(8'h10, 8'h02);
      settle();
      check("cal amp2", {10'h0, en3, cal_request}, 16'h0008);
      check("cmp3 off", {12'h0, thr3}, 16'h0000);
      done(2);
      rd(8'h10, 8'h00, "amp2 cleared");
   endtask
   task automatic shared_calibration(input logic bemf);
      n_off = 0;
      @(posedge clk_sys);
      backemf_sensing_enable <= bemf;
      wr(8'h10, 8'h01);
      settle();
      check("cal shared", 16'(cal_request), bemf ? 16'h0002 : 16'h0004);
      done(3);
      rd(8'h10, 8'h00, "shared cleared");
      check("offset clear", 16'(n_off), 16'(bemf));
   endtask
   task automatic deadtime_and_lock();
      n_lock = 0;
      wr(8'h12, 8'h00);
      settle();
      check("locked ignored", 16'(n_lock), 16'h0000);
      wr(8'h11, 8'hFF);
      settle();
      check("deadtime off", {15'h0, dt_en}, 16'h0000);
      rd(8'h11, 8'hA7, "reserved zero");
      wr(8'h12, 8'h40);
      settle();
      check("locked taken", 16'(n_lock), 16'h0001);
      wr(8'h11, 8'h00);
      wr(8'h12, 8'h00);
      settle();
      check("relocked", {14'h0, dt_en, 1'b0} | 16'(n_lock), 16'h0003);
   endtask
   task automatic monitor_codes();
      for (int b = 0; b < 2; b++) begin
         @(posedge clk_sys);
         backemf_sensing_enable <= b[0];
         for (int c = 0; c < 8; c++) begin
            wr(8'h11, {5'h00, c[2:0]});
            settle();
            check("route", 16'(monitor_route), 16'(route_exp(c[2:0], b[0])));
         end
      end
   endtask

   // =========================================================
   // verdict and end of run
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // =========================================================
   // main sequence: reset held for ten cycles
   initial begin
      {num_errors, checks_done, cycles, n_lock, n_off} = '0;
      rst_n = 1'b0;
      {reg_wr, backemf_sensing_enable, cal_done_one, cal_done_two, cal_done_three} = 5'h00;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      reset_and_thresholds();
      amp_calibrations();
      shared_calibration(1'b1);
      shared_calibration(1'b0);
      deadtime_and_lock();
      monitor_codes();
      end_of_test();
   end
endmodule // tb
